// ### spare_pin_params.svh
// Purpose: Constants for the spare pin port
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
`ifndef SPARE_PIN_PARAMS_SVH
`define SPARE_PIN_PARAMS_SVH

`define SP_NUM_PINS       6
`define SP_ADDR_W         8
`define SP_OFF_DIR        8'h00
`define SP_OFF_OUT        8'h04
`define SP_OFF_PULL       8'h08
`define SP_OFF_IN         8'h0c
`define SP_DIR_RST        6'h00
`define SP_OUT_RST        6'h00
`define SP_PULL_RST       12'h555
`define SP_PULL_LSB_W     2

`endif

// ### spare_pin_pkg.sv
// Purpose: Types for the spare pin port
// Assumes: Included parameters header
// Notes:   Pull selection encoding per pin
package spare_pin_pkg;
  typedef enum logic [1:0]
  {
    PULL_NONE   = 2'h0,
    PULL_WEAK   = 2'h1,
    PULL_STRONG = 2'h2,
    PULL_RSVD   = 2'h3
  } pull_sel_t;
endpackage

// ### spare_pin_port.sv
// Purpose: Six spare general purpose pins under software command
// Assumes: APB slave clocked by pclk, inputs synchronous to pclk
// Notes:   Pull code 3 behaves as no pull
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "spare_pin_params.svh"
`timescale 1ns/1ps
`default_nettype none

module spare_pin_port
(
  // Clock, reset, enable
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`SP_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Spare pins
  input  wire logic [`SP_NUM_PINS-1:0]   spare_pins_i,
  output logic      [`SP_NUM_PINS-1:0]   spare_pins_o,
  output logic      [`SP_NUM_PINS-1:0]   spare_pins_oe_n,
  output logic      [`SP_NUM_PINS-1:0]   pull_weak_en,
  output logic      [`SP_NUM_PINS-1:0]   pull_strong_en
);

  // Register state
  logic [`SP_NUM_PINS-1:0]     dir_q;
  logic [`SP_NUM_PINS-1:0]     dir_d;
  logic [`SP_NUM_PINS-1:0]     out_q;
  logic [`SP_NUM_PINS-1:0]     out_d;
  logic [2*`SP_NUM_PINS-1:0]   pull_q;
  logic [2*`SP_NUM_PINS-1:0]   pull_d;
  logic [`SP_NUM_PINS-1:0]     in_q;

  // Bus decode
  logic                        setup_ph;
  logic                        access_ph;
  logic                        wr_en;
  logic                        rd_en;
  logic                        addr_ok;
  logic [31:0]                 rdata_d;

  // Pin drive next values
  logic [`SP_NUM_PINS-1:0]     oe_n_d;
  logic [`SP_NUM_PINS-1:0]     weak_d;
  logic [`SP_NUM_PINS-1:0]     strong_d;

  // True when the pull field of pin i holds code s
  function automatic logic pull_is
  (
    input logic [2*`SP_NUM_PINS-1:0] p,
    input int                        i,
    input spare_pin_pkg::pull_sel_t  s
  );
    pull_is = (p[i*`SP_PULL_LSB_W +: `SP_PULL_LSB_W] == s);
  endfunction

  // True when the bus address selects the register at offset off
  function automatic logic reg_hit
  (
    input logic [`SP_ADDR_W-1:0] a,
    input logic [`SP_ADDR_W-1:0] off
  );
    reg_hit = (a == off);
  endfunction

  // Setup cycle opens a transfer; access cycle carries the registered answer
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable && pready;

  // Writes land at the edge where the master sees pready high
  assign wr_en = access_ph && pwrite && clk_en;
  assign rd_en = setup_ph && !pwrite && clk_en;

  // Read data and address check
  always_comb
  begin
    addr_ok = 1'b1;
    rdata_d = '0;
    if (reg_hit(paddr, `SP_OFF_DIR))
      rdata_d[`SP_NUM_PINS-1:0] = dir_q;
    else if (reg_hit(paddr, `SP_OFF_OUT))
      rdata_d[`SP_NUM_PINS-1:0] = out_q;
    else if (reg_hit(paddr, `SP_OFF_PULL))
      rdata_d[2*`SP_NUM_PINS-1:0] = pull_q;
    else if (reg_hit(paddr, `SP_OFF_IN))
      rdata_d[`SP_NUM_PINS-1:0] = in_q;
    else
      addr_ok = 1'b0;
  end

  // Register next values; unmapped writes change nothing
  always_comb
  begin
    dir_d  = dir_q;
    out_d  = out_q;
    pull_d = pull_q;
    if (wr_en && reg_hit(paddr, `SP_OFF_DIR))
      dir_d = pwdata[`SP_NUM_PINS-1:0];
    if (wr_en && reg_hit(paddr, `SP_OFF_OUT))
      out_d = pwdata[`SP_NUM_PINS-1:0];
    if (wr_en && reg_hit(paddr, `SP_OFF_PULL))
      pull_d = pwdata[2*`SP_NUM_PINS-1:0];
  end

  // Pulls only on inputs; code none leaves the pin floating
  always_comb
  begin
    oe_n_d   = '1;
    weak_d   = '0;
    strong_d = '0;
    for (int i = 0; i < `SP_NUM_PINS; i++)
    begin
      oe_n_d[i]   = !dir_q[i];
      weak_d[i]   = !dir_q[i] && pull_is(pull_q, i, spare_pin_pkg::PULL_WEAK);
      strong_d[i] = !dir_q[i] && pull_is(pull_q, i, spare_pin_pkg::PULL_STRONG);
    end
  end

  // Ready: one access cycle after every setup cycle that has clk_en high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else if (clk_en)
      pready <= setup_ph;
  end

  // Error flag for unmapped addresses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (clk_en)
      pslverr <= setup_ph && !addr_ok;
  end

  // Read data stands in the access cycle only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (clk_en)
      prdata <= rd_en ? rdata_d : '0;
  end

  // Direction register, only path of control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_q <= `SP_DIR_RST;
    else if (clk_en)
      dir_q <= dir_d;
  end

  // Output level register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= `SP_OUT_RST;
    else if (clk_en)
      out_q <= out_d;
  end

  // Pull selection register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pull_q <= `SP_PULL_RST;
    else if (clk_en)
      pull_q <= pull_d;
  end

  // Input sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_q <= '0;
    else if (clk_en)
      in_q <= spare_pins_i;
  end

  // Drive levels; six independent pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spare_pins_o <= `SP_OUT_RST;
    else if (clk_en)
      spare_pins_o <= out_q;
  end

  // Output enables, off until a pin is made an output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spare_pins_oe_n <= '1;
    else if (clk_en)
      spare_pins_oe_n <= oe_n_d;
  end

  // Weak pull-up enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pull_weak_en <= '1;
    else if (clk_en)
      pull_weak_en <= weak_d;
  end

  // Strong pull-up enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pull_strong_en <= '0;
    else if (clk_en)
      pull_strong_en <= strong_d;
  end

endmodule

`default_nettype wire

// ### spare_pin_monitor.sv
// Purpose: port checker
// Assumes: clk_en high
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module spare_pin_monitor (
  // Bus
  input wire logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  // Pins
  input wire logic [5:0] spare_pins_o, spare_pins_oe_n, pull_weak_en, pull_strong_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wa = psel && penable && pready && pwrite && clk_en;
  a_reset_pins: assert property ($rose(presetn) |-> &spare_pins_oe_n && &pull_weak_en) else $error("reset");
  a_drive_cause: assert property (!$stable(spare_pins_oe_n) |-> $past(wa && paddr == 8'h00, 2)) else $error("oe");
  a_level_cause: assert property (!$stable(spare_pins_o) |-> $past(wa && paddr == 8'h04, 2)) else $error("out");
  a_pull_drive: assert property (((pull_weak_en | pull_strong_en) & ~spare_pins_oe_n) == 6'h00) else $error("pu");
  a_pull_one: assert property ((pull_weak_en & pull_strong_en) == 6'h00) else $error("pulls");
  a_ready_once: assert property (clk_en && psel && !penable |=> pready ##1 !pready) else $error("ready");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("err");
  c_dir: cover property (wa && paddr == 8'h00);
  c_in: cover property (pready && paddr == 8'h0c);
  c_err: cover property (pready && pslverr);
endmodule
bind spare_pin_port spare_pin_monitor mon (.*);
`default_nettype wire

// ### pin_load_model.sv
// Purpose: pin loads
// Assumes: switch grounds pin
// Notes: open pin toggles
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (input wire logic pclk, input wire logic [5:0] o, oe_n, pw, ps, sw, output logic [5:0] lvl);
  logic [5:0] flt_q = 6'h2a;
  always @(posedge pclk) flt_q <= ~flt_q;
  assign lvl = ~oe_n & o | oe_n & ~sw & (pw | ps | flt_q);
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: port bench
// Assumes: pins 2,3 grounded
// Notes: row is {w,err}, addr, data
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin num_checks++; if ((a)!==(e)) begin miscompares++; $display("[ERR] %0t bad",$time); end end
module tb_top;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] spare_pins_i, spare_pins_o, spare_pins_oe_n, pull_weak_en, pull_strong_en;
  logic [43:0] rows [10] = '{44'h0_00_00000000, 44'h0_08_00000555, 44'h0_04_00000000, 44'h2_08_00000039,
    44'h2_04_0000003f, 44'h2_00_00000030, 44'h0_00_00000030, 44'h1_10_00000000, 44'h3_10_00000000, 44'h0_0c_00000033};
  int miscompares, num_checks, cyc;
  spare_pin_port dut (.*);
  pin_load_model ld (.pclk, .o(spare_pins_o), .oe_n(spare_pins_oe_n), .pw(pull_weak_en), .ps(pull_strong_en),
    .sw(6'h0c), .lvl(spare_pins_i));
  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic [43:0] r);
    {psel, penable} <= 2'b10;
    {pwrite, paddr, pwdata} <= {r[41], r[39:0]};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    `CHK(pslverr, r[40])
    `CHK(prdata, r[41] ? 32'h0 : r[31:0])
  endtask
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (++cyc > 500)
    begin
      miscompares++;
      summarize();
    end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) apb(rows[i]);
    {psel, penable} <= 2'b00;
    @(posedge pclk);
    `CHK(spare_pins_oe_n, 6'h0f)
    `CHK(pull_weak_en, 6'h01)
    `CHK(pull_strong_en, 6'h02)
    clk_en <= 1'b0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, 1'b1, 8'h00, 32'h0000003f};
    repeat (3) @(posedge pclk);
    `CHK(pready, 1'b0)
    `CHK(spare_pins_oe_n, 6'h0f)
    {psel, clk_en} <= 2'b01;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    @(posedge pclk);
    `CHK(spare_pins_oe_n, 6'h3f)
    `CHK(pull_weak_en, 6'h3f)
    summarize();
  end
endmodule
`default_nettype wire
